// *** core/lxd_decoder.sv ***
// io-cycle to peripheral-bus decoder: address match, chip selects, strobes, data path
// assumes a front end that presents one decoded io cycle as a start pulse and waits for done_o
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - up to four 8-bit peripherals, each spanning four port addresses in mode one, sixteen in mode two
// - mode one: four selects, two address lines; mode two: two selects, four
// - drive read strobe, write strobe and an 8-bit two-way data bus
// - each select comes from comparing cycle address with its base address
// - mode comes from bit 0 of the peripheral-bus selection register
// - mode one compares bits 15..2, passes bits 1..0 through
// - mode two compares bits 15..4, passes bits 3..0 through
// - a select is low only during its matching cycle
// - a match needs address bits 15..12 all zero when bit 6 of the global osc config register is set
// - strobes pulse only during a matching cycle
// - a disabled select never asserts
// - write-once protect bit, cleared only by power-on or hard reset
// - protect blocks writes to both base bytes and the disable bit
// - strobe pulse widths come from the selection register
module lxd_decoder
   import lxd_pkg::*;
#(
   parameter int NUM_SEL = LXD_NUM_SEL
)(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic start_i,
   input wire lxd_cycle_t cycle_i,
   input wire logic [7:0] bus_sel_cfg_i,
   input wire logic [7:0] global_osc_config_reg_i,
   input wire logic cfg_we_i,
   input wire lxd_cfg_wr_t cfg_i,
   input wire logic [LXD_DATA_W-1:0] periph_data_i,
   output logic [LXD_DATA_W-1:0] periph_data_o,
   output logic periph_data_oe_o,
   output logic [NUM_SEL-1:0] periph_select_n_o,
   output logic [3:0] periph_addr_o,
   output logic periph_read_strobe_n_o,
   output logic periph_write_strobe_n_o,
   output logic hit_o,
   output logic done_o,
   output logic [LXD_DATA_W-1:0] rdata_o
);
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_DONE} lxd_state_t;

   typedef struct packed {
      lxd_state_t st;
      logic [3:0] cnt;
      logic wr;
      logic [NUM_SEL-1:0] sel_n;
      logic [3:0] addr;
      logic rd_n;
      logic wr_n;
      logic [LXD_DATA_W-1:0] dout;
      logic oe;
      logic hit;
      logic done;
      logic [LXD_DATA_W-1:0] rdata;
   } lxd_dec_t;

   // idle image of the machine: selects and strobes high, bus released
   localparam lxd_dec_t DEC_IDLE = '{
      st: ST_IDLE,
      cnt: 4'h0,
      wr: 1'b0,
      sel_n: '1,
      addr: 4'h0,
      rd_n: 1'b1,
      wr_n: 1'b1,
      dout: 8'h00,
      oe: 1'b0,
      hit: 1'b0,
      done: 1'b0,
      rdata: 8'h00
   };

   lxd_dec_t s_q, s_d;
   lxd_base_t [LXD_NUM_SEL-1:0] base;

   lxd_base_regs u_regs (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .en_i(en_i),
      .cfg_we_i(cfg_we_i),
      .cfg_i(cfg_i),
      .base_o(base)
   );

   // compare one base register against the cycle address under the chosen mode
   function automatic logic base_match(input lxd_base_t b, input logic [15:0] a,
                                       input logic mode2, input logic qual);
      logic [15:0] bv;
      logic hit;
      bv = {b.hi, b.lo};
      if (mode2) begin
         hit = (a[15:LXD_M2_LO] == bv[15:LXD_M2_LO]);
      end else begin
         hit = (a[15:LXD_M1_LO] == bv[15:LXD_M1_LO]);
      end
      // full qualification needs the upper nibble zero
      if (qual && (a[15:LXD_TOP_LO] != LXD_TOP_ZERO)) begin
         hit = 1'b0;
      end
      return hit && !b.disable_sel;
   endfunction

   logic mode2;
   logic qual;
   logic [NUM_SEL-1:0] match;
   logic [LXD_PW_W:0] pw;

   assign mode2 = bus_sel_cfg_i[LXD_MODE_BIT];
   assign qual = global_osc_config_reg_i[LXD_QUAL_BIT];
   // strobe width in cycles, from the selection register
   assign pw = {1'b0, bus_sel_cfg_i[LXD_PW_LO +: LXD_PW_W]} + LXD_PW_MIN;

   // in mode two only the first two selects exist
   genvar g;
   generate
      for (g = 0; g < NUM_SEL; g++) begin : g_match
         if (g < 2) begin : g_both
            assign match[g] = base_match(base[g], cycle_i.addr, mode2, qual);
         end else begin : g_m1
            assign match[g] = !mode2 && base_match(base[g], cycle_i.addr, mode2, qual);
         end
      end
   endgenerate

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      unique case (s_q.st)
         ST_IDLE: begin
            // a start while busy is dropped unflagged, so the front end must wait for done_o
            if (start_i) begin
               s_d.hit = |match;
               if (|match) begin
                  // first match wins if bases overlap
                  for (int i = NUM_SEL - 1; i >= 0; i--) begin
                     if (match[i]) begin
                        s_d.sel_n = '1;
                        s_d.sel_n[i] = 1'b0;
                     end
                  end
                  // pass-through address bits
                  s_d.addr = mode2 ? cycle_i.addr[3:0] : {2'b00, cycle_i.addr[1:0]};
                  s_d.wr = cycle_i.write;
                  s_d.dout = cycle_i.wdata;
                  s_d.cnt = 4'(LXD_SETUP_CYC);
                  s_d.st = ST_SETUP;
               end else begin
                  // non-matching cycle: no strobe, finish at once
                  s_d.done = 1'b1;
               end
            end
         end
         ST_SETUP: begin
            // select and address settle before the strobe falls, so peripherals see a stable decode
            if (s_q.cnt > 4'h1) begin
               s_d.cnt = s_q.cnt - 4'h1;
            end else begin
               s_d.cnt = pw;
               s_d.rd_n = s_q.wr;
               s_d.wr_n = !s_q.wr;
               s_d.oe = s_q.wr;
               s_d.st = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (s_q.cnt > 4'h1) begin
               s_d.cnt = s_q.cnt - 4'h1;
            end else begin
               // sample read data as the strobe ends
               if (!s_q.wr) begin
                  s_d.rdata = periph_data_i;
               end
               s_d.rd_n = 1'b1;
               s_d.wr_n = 1'b1;
               s_d.oe = 1'b0;
               s_d.cnt = 4'(LXD_HOLD_CYC);
               s_d.st = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (s_q.cnt > 4'h1) begin
               s_d.cnt = s_q.cnt - 4'h1;
            end else begin
               s_d.sel_n = '1;
               s_d.st = ST_DONE;
            end
         end
         ST_DONE: begin
            s_d.done = 1'b1;
            s_d.st = ST_IDLE;
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
   end

   // reset leaves every select and strobe high
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= DEC_IDLE;
      end else if (en_i) begin
         s_q <= s_d;
      end
   end

   assign periph_select_n_o = s_q.sel_n;
   assign periph_addr_o = s_q.addr;
   assign periph_read_strobe_n_o = s_q.rd_n;
   assign periph_write_strobe_n_o = s_q.wr_n;
   assign periph_data_o = s_q.dout;
   assign periph_data_oe_o = s_q.oe;
   assign hit_o = s_q.hit;
   assign done_o = s_q.done;
   assign rdata_o = s_q.rdata;
endmodule
`default_nettype wire

// *** core/lxd_pkg.sv ***
// package for the io-cycle to peripheral-bus decoder: field layouts, carriers, timing
// assumes one 50 MHz clock shared by the cycle front end and the decoder
package lxd_pkg;
   localparam int LXD_NUM_SEL = 4;
   localparam int LXD_ADDR_W = 16;
   localparam int LXD_DATA_W = 8;
   localparam int LXD_MODE_BIT = 0;
   localparam logic [7:0] LXD_SELREG_IDX = 8'hF0;
   localparam int LXD_QUAL_BIT = 6;
   localparam int LXD_M1_LO = 2;
   localparam int LXD_M2_LO = 4;
   localparam int LXD_TOP_LO = 12;
   localparam logic [3:0] LXD_TOP_ZERO = 4'h0;
   localparam int LXD_PW_LO = 1;
   localparam int LXD_PW_W = 3;
   localparam int LXD_CLK_NS = 20;
   localparam int LXD_SETUP_NS = 20;
   localparam int LXD_HOLD_NS = 20;
   localparam int LXD_SETUP_CYC = (LXD_SETUP_NS + LXD_CLK_NS - 1) / LXD_CLK_NS;
   localparam int LXD_HOLD_CYC = (LXD_HOLD_NS + LXD_CLK_NS - 1) / LXD_CLK_NS;
   localparam logic [LXD_PW_W:0] LXD_PW_MIN = 4'h1;

   typedef struct packed {
      logic [LXD_ADDR_W-1:0] addr;
      logic [LXD_DATA_W-1:0] wdata;
      logic write;
   } lxd_cycle_t;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
      logic disable_sel;
      logic protect;
   } lxd_base_t;

   typedef struct packed {
      logic [LXD_NUM_SEL-1:0] sel;
      logic [7:0] hi;
      logic [7:0] lo;
      logic disable_sel;
      logic protect;
   } lxd_cfg_wr_t;
endpackage

// *** core/lxd_base_regs.sv ***
// four base-address registers with disable and write-once protect bits
// assumes config writes arrive as single-cycle strobes on the decoder clock
`timescale 1ns/10ps
`default_nettype none
module lxd_base_regs
   import lxd_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic cfg_we_i,
   input wire lxd_cfg_wr_t cfg_i,
   output lxd_base_t [LXD_NUM_SEL-1:0] base_o
);
   typedef struct packed {
      lxd_base_t [LXD_NUM_SEL-1:0] base;
   } lxd_regs_t;

   lxd_regs_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      for (int i = 0; i < LXD_NUM_SEL; i++) begin
         if (en_i && cfg_we_i && cfg_i.sel[i] && !s_q.base[i].protect) begin
            // protected registers ignore the whole write, disable bit included
            s_d.base[i].hi = cfg_i.hi;
            s_d.base[i].lo = cfg_i.lo;
            s_d.base[i].disable_sel = cfg_i.disable_sel;
            // set once: only reset clears it again
            s_d.base[i].protect = cfg_i.protect;
         end
      end
   end

   // nrst_i is the power-on / hard host reset
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign base_o = s_q.base;
endmodule
`default_nettype wire

// *** bench/lxd_decoder_checker.sv ***
// checker for the decoder ports: strobe timing, select shape, idle levels
// assumes binding onto lxd_decoder, one clock, en_i dropped only while no cycle is started
`timescale 1ns/10ps
`default_nettype none
module lxd_decoder_checker
   import lxd_pkg::*;
#(parameter int NUM_SEL = LXD_NUM_SEL)(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic start_i,
   input wire lxd_cycle_t cycle_i,
   input wire logic [7:0] bus_sel_cfg_i,
   input wire logic [7:0] global_osc_config_reg_i,
   input wire logic periph_data_oe_o,
   input wire logic [NUM_SEL-1:0] periph_select_n_o,
   input wire logic periph_read_strobe_n_o,
   input wire logic periph_write_strobe_n_o,
   input wire logic hit_o,
   input wire logic done_o
);
   logic busy_q;
   logic [3:0] cnt_q;
   wire strb = periph_read_strobe_n_o & periph_write_strobe_n_o;
   wire taken = start_i & !busy_q;
   // busy spans take to done, so idle checks never see a live cycle
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_q <= 1'b0;
         cnt_q <= 4'h0;
      end else begin
         busy_q <= done_o ? 1'b0 : (busy_q | taken);
         cnt_q <= strb ? 4'h0 : cnt_q + 4'h1;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   AST_IDLE: assert property (!busy_q |-> strb && &periph_select_n_o)
      else $error("select or strobe active while idle");
   AST_OE: assert property (periph_data_oe_o == !periph_write_strobe_n_o)
      else $error("data enable not aligned to write strobe");
   AST_SETUP: assert property ($fell(strb) |-> !(&$past(periph_select_n_o)))
      else $error("strobe without select setup");
   AST_HOLD: assert property ($rose(strb) |-> !(&periph_select_n_o))
      else $error("select released before strobe");
   AST_PW: assert property ($rose(strb) |-> cnt_q == {1'b0, bus_sel_cfg_i[3:1]} + 4'h1)
      else $error("strobe width wrong");
   AST_ONEHOT: assert property ($onehot0(~periph_select_n_o))
      else $error("more than one select low");
   AST_MODE2: assert property (bus_sel_cfg_i[LXD_MODE_BIT] |-> &periph_select_n_o[3:2])
      else $error("upper select active in mode two");
   AST_QUAL: assert property (taken && global_osc_config_reg_i[LXD_QUAL_BIT]
      && cycle_i.addr[15:12] != LXD_TOP_ZERO |=> (strb && &periph_select_n_o) [*3])
      else $error("cycle above 4K decoded");
   cover property ($fell(periph_write_strobe_n_o));
   cover property ($fell(periph_read_strobe_n_o));
   cover property (done_o && !hit_o);
endmodule
bind lxd_decoder lxd_decoder_checker #(.NUM_SEL(NUM_SEL)) chk_u (.clock_i, .nrst_i, .start_i,
   .cycle_i, .bus_sel_cfg_i, .global_osc_config_reg_i, .periph_data_oe_o, .periph_select_n_o,
   .periph_read_strobe_n_o, .periph_write_strobe_n_o, .hit_o, .done_o);
`default_nettype wire

// *** bench/lxd_periph_model.sv ***
// four byte-wide peripherals, 16 bytes each, behind the selects
// assumes the bench resolves the data bus from the decoder's output enable
`timescale 1ns/10ps
`default_nettype none
module lxd_periph_model (
   input wire logic clock_i,
   input wire logic [3:0] sel_n_i,
   input wire logic [3:0] addr_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o
);
   logic [7:0] mem [64];
   logic [7:0] junk = 8'h5A;
   logic [1:0] s;
   assign s = !sel_n_i[0] ? 2'h0 : !sel_n_i[1] ? 2'h1 : !sel_n_i[2] ? 2'h2 : 2'h3;
   // no pull on the bus: an undriven bus shows a pattern that moves every cycle
   always @(posedge clock_i) begin
      junk <= ~junk;
      if (!wr_n_i && !(&sel_n_i)) mem[{s, addr_i}] <= data_i;
   end
   assign data_o = (!rd_n_i && !(&sel_n_i)) ? mem[{s, addr_i}] : junk;
endmodule
`default_nettype wire

// *** bench/lxd_decoder_bench.sv ***
// bench for the decoder: both modes, disable, write-once protect, qualification
// assumes the peripheral model on the far side; en_i drops only while the decoder is idle
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
   $display("mismatch %s expected %h seen %h", n, e, s); end end
module lxd_decoder_bench;
   import lxd_pkg::*;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic start_i = 1'b0;
   logic cfg_we_i = 1'b0;
   logic en = 1'b1;
   lxd_cycle_t cycle_i = '0;
   lxd_cfg_wr_t cfg_i = '0;
   logic [7:0] bus_sel_cfg_i = 8'h00;
   logic [7:0] osc = 8'h40;
   logic [7:0] dout, mdat, rdata;
   logic [3:0] sel_n, addr;
   logic oe, rd_n, wr_n, hit, done;
   wire [7:0] bus = oe ? dout : mdat;
   int err_count = 0;
   int comparisons = 0;
   int cyc = 0;
   lxd_decoder dut_u (.clock_i, .nrst_i, .en_i(en), .start_i, .cycle_i, .bus_sel_cfg_i,
      .global_osc_config_reg_i(osc), .cfg_we_i, .cfg_i, .periph_data_i(bus),
      .periph_data_o(dout), .periph_data_oe_o(oe), .periph_select_n_o(sel_n),
      .periph_addr_o(addr), .periph_read_strobe_n_o(rd_n), .periph_write_strobe_n_o(wr_n),
      .hit_o(hit), .done_o(done), .rdata_o(rdata));
   lxd_periph_model per_u (.clock_i, .sel_n_i(sel_n), .addr_i(addr), .rd_n_i(rd_n),
      .wr_n_i(wr_n), .data_i(bus), .data_o(mdat));
   initial forever #10 clock_i = ~clock_i;
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic cfg(input logic [3:0] s, input logic [15:0] b, input logic d, input logic p);
      @(posedge clock_i);
      cfg_we_i <= 1'b1;
      cfg_i <= '{s, b[15:8], b[7:0], d, p};
      @(posedge clock_i);
      cfg_we_i <= 1'b0;
   endtask
   // for reads d is the byte expected back
   task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d, input logic h);
      int n;
      n = 0;
      @(posedge clock_i);
      start_i <= 1'b1;
      cycle_i <= '{a, d, w};
      @(posedge clock_i);
      start_i <= 1'b0;
      while (done !== 1'b1 && n < 40) begin
         @(posedge clock_i);
         n++;
      end
      `CHK("done", 1'b1, done)
      `CHK("hit", h, hit)
      if (!w && h) `CHK("read data", d, rdata)
   endtask
   task automatic t_reset;
      `CHK("idle selects", 4'hF, sel_n)
      `CHK("idle strobes", 2'h3, {rd_n, wr_n})
      `CHK("idle data enable", 1'b0, oe)
   endtask
   task automatic t_mode1;
      cfg(4'h1, 16'h0300, 1'b0, 1'b0);
      cfg(4'h2, 16'h0304, 1'b0, 1'b0);
      io(16'h0301, 1'b1, 8'hA5, 1'b1);
      io(16'h0302, 1'b1, 8'h5A, 1'b1);
      io(16'h0305, 1'b1, 8'hC3, 1'b1);
      io(16'h0301, 1'b0, 8'hA5, 1'b1);
      io(16'h0305, 1'b0, 8'hC3, 1'b1);
      io(16'h0308, 1'b0, 8'h00, 1'b0);
   endtask
   task automatic t_protect;
      cfg(4'h2, 16'h0304, 1'b1, 1'b0);
      io(16'h0305, 1'b0, 8'hC3, 1'b0);
      cfg(4'h1, 16'h0300, 1'b0, 1'b1);
      cfg(4'h1, 16'h0400, 1'b1, 1'b0);
      io(16'h0301, 1'b0, 8'hA5, 1'b1);
      io(16'h0401, 1'b0, 8'hA5, 1'b0);
   endtask
   task automatic t_qual;
      cfg(4'h4, 16'h1200, 1'b0, 1'b0);
      io(16'h1200, 1'b1, 8'h11, 1'b0);
      osc <= 8'h00;
      io(16'h1200, 1'b1, 8'h11, 1'b1);
   endtask
   task automatic t_mode2;
      bus_sel_cfg_i <= 8'h07;
      io(16'h1200, 1'b1, 8'h11, 1'b0);
      io(16'h030D, 1'b1, 8'h3C, 1'b1);
      io(16'h0301, 1'b0, 8'hA5, 1'b1);
      io(16'h030D, 1'b0, 8'h3C, 1'b1);
   endtask
   // a hard reset in mid-run clears the write-once protect bits again
   task automatic t_rerst;
      @(posedge clock_i);
      nrst_i <= 1'b0;
      @(posedge clock_i);
      @(posedge clock_i);
      `CHK("selects in reset", 4'hF, sel_n)
      `CHK("strobes in reset", 2'h3, {rd_n, wr_n})
      nrst_i <= 1'b1;
      @(posedge clock_i);
      cfg(4'h1, 16'h0400, 1'b0, 1'b0);
      io(16'h0401, 1'b0, 8'hA5, 1'b1);
      io(16'h0301, 1'b0, 8'hA5, 1'b0);
   endtask
   // a config write with the clock enable low must not land
   task automatic t_freeze;
      en <= 1'b0;
      cfg(4'h2, 16'h0500, 1'b0, 1'b0);
      en <= 1'b1;
      io(16'h0501, 1'b0, 8'h00, 1'b0);
   endtask
   initial begin
      repeat (12) @(posedge clock_i);
      nrst_i <= 1'b1;
      @(posedge clock_i);
      t_reset();
      t_mode1();
      t_protect();
      t_qual();
      t_mode2();
      t_rerst();
      t_freeze();
      end_of_test();
   end
endmodule
`default_nettype wire
